// *** host_cmd_cfg.svh ***
// Register map, field positions, reset values and timing counts of the host
// command block. Included by the micro-frame timer and the command control module.
`ifndef HOST_CMD_CFG_SVH
`define HOST_CMD_CFG_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define HC_OFS_COMMAND   12'h000
`define HC_OFS_STATUS    12'h004
`define HC_OFS_CAPS      12'h008
`define HC_OFS_FRINDEX   12'h00C
`define HC_OFS_PLBASE    12'h010
`define HC_OFS_PORTROUTE 12'h014

// ************************************************************
// Field positions
// ************************************************************
`define HC_CMD_RS        0
`define HC_CMD_SRST      1
`define HC_CMD_FLS_LO    2
`define HC_CMD_FLS_HI    3
`define HC_CMD_PSE       4
`define HC_CMD_ASE       5
`define HC_STS_HALTED    12
`define HC_CAP_PROG_FLS  1

// ************************************************************
// Reset values and encodings
// ************************************************************
`define HC_FLS_1024      2'h0
`define HC_FLS_512       2'h1
`define HC_FLS_256       2'h2
`define HC_FLS_RSVD      2'h3
`define HC_FLS_RESET     2'h0

// ************************************************************
// Timing
// ************************************************************
`define HC_CLK_PERIOD_NS 40
`define HC_UFRAME_NS     125000
`define HC_UFRAME_CYC    (`HC_UFRAME_NS / `HC_CLK_PERIOD_NS)
`define HC_STOP_UFRAMES  16
`define HC_SRST_CYC      8

`endif

// *** host_cmd_pkg.sv ***
// Types shared by the host command block.
// Assumes host_cmd_cfg.svh is on the include path.
package host_cmd_pkg;

    // Schedule engine states.
    typedef enum logic [1:0] {
        ST_HALTED,
        ST_RUNNING,
        ST_STOPPING
    } sched_state_t;

endpackage

// *** uframe_timer.sv ***
// Micro-frame timer and frame index counter of the host command block.
// Assumes one 25 MHz clock and a parent that decides when it runs.
`timescale 1ns/1ps
`include "host_cmd_cfg.svh"

module uframe_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        run,
    input  wire logic        clear,
    input  wire logic        load,
    input  wire logic [13:0] load_val,
    output logic             tick,
    output logic [13:0]      frame_index
);

    // ************************************************************
    // Cycle counter for one micro-frame
    // ************************************************************
    localparam logic [11:0] LAST = 12'(`HC_UFRAME_CYC - 1);

    logic [11:0] cyc_q;

    // The counter only advances while the schedule runs, so a halted
    // controller keeps a stable frame index for software to read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= 12'h000;
        end else if (clear || !run) begin
            cyc_q <= 12'h000;
        end else if (cyc_q == LAST) begin
            cyc_q <= 12'h000;
        end else begin
            cyc_q <= cyc_q + 12'h001;
        end
    end

    // One-cycle pulse at the end of each micro-frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
        end else begin
            tick <= run && !clear && (cyc_q == LAST);
        end
    end

    // ************************************************************
    // Frame index, counted in micro-frames
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_index <= 14'h0000;
        end else if (clear) begin
            frame_index <= 14'h0000;
        end else if (load) begin
            frame_index <= load_val;
        end else if (run && cyc_q == LAST) begin
            frame_index <= frame_index + 14'h0001;
        end
    end

endmodule

// *** usb_host_command_control.sv ***
// Command, run/stop and soft reset logic of a high-speed USB host
// controller, reached over APB.
// Assumes an APB master on pclk and a transaction engine on the same clock.
`timescale 1ns/1ps
`include "host_cmd_cfg.svh"

module usb_host_command_control #(
    parameter logic PROG_FLS = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic        usb_xact_busy,
    output logic             sched_run_q,
    output logic             periodic_active_q,
    output logic             async_active_q,
    output logic             periodic_fetch_q,
    output logic [31:0]      periodic_fetch_addr_q,
    output logic [9:0]       frame_list_index_q,
    output logic             xact_kill_q,
    output logic             usb_bus_reset_q,
    output logic             companion_own_q
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Frame list entry index taken from the micro-frame counter.
    function automatic logic [9:0] list_index(input logic [1:0] frame_list_size,
                                              input logic [13:0] fi);
        logic [9:0] idx;
        idx = 10'h000;
        case (frame_list_size)
            `HC_FLS_512: idx = {1'b0, fi[11:3]};
            `HC_FLS_256: idx = {2'b00, fi[10:3]};
            default:     idx = fi[12:3];
        endcase
        return idx;
    endfunction

    // True when an address hits a mapped register.
    function automatic logic mapped(input logic [11:0] a);
        return a == `HC_OFS_COMMAND || a == `HC_OFS_STATUS ||
               a == `HC_OFS_CAPS || a == `HC_OFS_FRINDEX ||
               a == `HC_OFS_PLBASE || a == `HC_OFS_PORTROUTE;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    host_cmd_pkg::sched_state_t st_q;
    logic        run_stop_bit_q;
    logic        soft_reset_q;
    logic [1:0]  frame_list_size_q;
    logic        periodic_sched_enable_q;
    logic        async_sched_enable_q;
    logic        halted_flag_q;
    logic [31:0] periodic_list_base_q;
    logic        port_route_q;
    logic [3:0]  srst_cnt_q;
    logic [4:0]  stop_uf_q;
    logic        wr_acc;
    logic        rd_setup;
    logic        srst_done;
    logic        uf_tick;
    logic [13:0] frame_index;
    logic [31:0] rd_word;

    assign wr_acc    = psel && penable && pready && pwrite && !pslverr;
    assign rd_setup  = psel && !penable;
    assign srst_done = soft_reset_q && (srst_cnt_q == 4'(`HC_SRST_CYC - 1));

    // ************************************************************
    // APB slave
    // ************************************************************

    // Zero wait state: ready is raised for the access phase that follows
    // every setup cycle, and an unmapped address answers with an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_setup;
            pslverr <= rd_setup && !mapped(paddr);
        end
    end

    // Read word assembly; reserved bits read as zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            `HC_OFS_COMMAND: begin
                rd_word[`HC_CMD_RS]                     = run_stop_bit_q;
                rd_word[`HC_CMD_SRST]                   = soft_reset_q;
                rd_word[`HC_CMD_FLS_HI:`HC_CMD_FLS_LO]  = frame_list_size_q;
                rd_word[`HC_CMD_PSE]                    = periodic_sched_enable_q;
                rd_word[`HC_CMD_ASE]                    = async_sched_enable_q;
            end
            `HC_OFS_STATUS:    rd_word[`HC_STS_HALTED]   = halted_flag_q;
            `HC_OFS_CAPS:      rd_word[`HC_CAP_PROG_FLS] = PROG_FLS;
            `HC_OFS_FRINDEX:   rd_word[13:0]             = frame_index;
            `HC_OFS_PLBASE:    rd_word = {periodic_list_base_q[31:12], 12'h000};
            `HC_OFS_PORTROUTE: rd_word[0]                = port_route_q;
            default:           rd_word = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle so it is a flop output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // ************************************************************
    // Command register
    // ************************************************************

    // Writes are ignored while the soft reset runs, so a zero written to
    // the reset bit cannot cut it short. The engine relies on software
    // only setting run or reset while halted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_stop_bit_q          <= 1'b0;
            frame_list_size_q       <= `HC_FLS_RESET;
            periodic_sched_enable_q <= 1'b0;
            async_sched_enable_q    <= 1'b0;
            periodic_list_base_q    <= 32'h0000_0000;
            port_route_q            <= 1'b0;
        end else if (srst_done) begin
            run_stop_bit_q          <= 1'b0;
            frame_list_size_q       <= `HC_FLS_RESET;
            periodic_sched_enable_q <= 1'b0;
            async_sched_enable_q    <= 1'b0;
            periodic_list_base_q    <= 32'h0000_0000;
            port_route_q            <= 1'b0;
        end else if (wr_acc && !soft_reset_q) begin
            case (paddr)
                `HC_OFS_COMMAND: begin
                    run_stop_bit_q          <= pwdata[`HC_CMD_RS];
                    periodic_sched_enable_q <= pwdata[`HC_CMD_PSE];
                    async_sched_enable_q    <= pwdata[`HC_CMD_ASE];
                    if (PROG_FLS &&
                        pwdata[`HC_CMD_FLS_HI:`HC_CMD_FLS_LO] != `HC_FLS_RSVD) begin
                        frame_list_size_q <= pwdata[`HC_CMD_FLS_HI:`HC_CMD_FLS_LO];
                    end
                end
                `HC_OFS_PLBASE:    periodic_list_base_q <= {pwdata[31:12], 12'h000};
                `HC_OFS_PORTROUTE: port_route_q         <= pwdata[0];
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Soft reset sequencer
    // ************************************************************

    // The reset bit self-clears after a fixed number of cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_q <= 1'b0;
            srst_cnt_q   <= 4'h0;
        end else if (soft_reset_q) begin
            soft_reset_q <= !srst_done;
            srst_cnt_q   <= srst_done ? 4'h0 : srst_cnt_q + 4'h1;
        end else if (wr_acc && paddr == `HC_OFS_COMMAND && pwdata[`HC_CMD_SRST]) begin
            soft_reset_q <= 1'b1;
            srst_cnt_q   <= 4'h0;
        end
    end

    // ************************************************************
    // Schedule engine
    // ************************************************************

    // A stop waits for the pipelined transactions to drain, but never
    // longer than the micro-frame limit; a soft reset overrides all.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= host_cmd_pkg::ST_HALTED;
            stop_uf_q <= 5'h00;
        end else if (soft_reset_q) begin
            st_q      <= host_cmd_pkg::ST_HALTED;
            stop_uf_q <= 5'h00;
        end else begin
            case (st_q)
                host_cmd_pkg::ST_HALTED: begin
                    stop_uf_q <= 5'h00;
                    if (run_stop_bit_q) begin
                        st_q <= host_cmd_pkg::ST_RUNNING;
                    end
                end
                host_cmd_pkg::ST_RUNNING: begin
                    if (!run_stop_bit_q) begin
                        st_q <= host_cmd_pkg::ST_STOPPING;
                    end
                end
                host_cmd_pkg::ST_STOPPING: begin
                    if (!usb_xact_busy ||
                        stop_uf_q == 5'(`HC_STOP_UFRAMES - 1) && uf_tick) begin
                        st_q <= host_cmd_pkg::ST_HALTED;
                    end else if (uf_tick) begin
                        stop_uf_q <= stop_uf_q + 5'h01;
                    end
                end
                default: st_q <= host_cmd_pkg::ST_HALTED;
            endcase
        end
    end

    // Halted flag mirrors entry to and exit from the stopped state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halted_flag_q <= 1'b1;
        end else begin
            halted_flag_q <= (st_q == host_cmd_pkg::ST_HALTED);
        end
    end

    // Micro-frame timer; the frame index is writable only while halted.
    uframe_timer u_timer (
        .pclk        (pclk),
        .presetn     (presetn),
        .run         (st_q != host_cmd_pkg::ST_HALTED),
        .clear       (soft_reset_q),
        .load        (wr_acc && paddr == `HC_OFS_FRINDEX && halted_flag_q),
        .load_val    (pwdata[13:0]),
        .tick        (uf_tick),
        .frame_index (frame_index)
    );

    // ************************************************************
    // Schedule outputs
    // ************************************************************

    // Schedule gates; both drop as soon as a stop is requested, while the
    // engine itself keeps sched_run_q up until the pipeline drains or the stop limit runs out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sched_run_q       <= 1'b0;
            periodic_active_q <= 1'b0;
            async_active_q    <= 1'b0;
        end else begin
            sched_run_q       <= st_q != host_cmd_pkg::ST_HALTED && !soft_reset_q;
            periodic_active_q <= st_q == host_cmd_pkg::ST_RUNNING &&
                                 periodic_sched_enable_q && !soft_reset_q;
            async_active_q    <= st_q == host_cmd_pkg::ST_RUNNING &&
                                 async_sched_enable_q && !soft_reset_q;
        end
    end

    // Frame list walk: one fetch per frame, through the periodic base.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_list_index_q    <= 10'h000;
            periodic_fetch_q      <= 1'b0;
            periodic_fetch_addr_q <= 32'h0000_0000;
        end else begin
            frame_list_index_q <= list_index(frame_list_size_q, frame_index);
            periodic_fetch_q   <= periodic_active_q && uf_tick &&
                                  frame_index[2:0] == 3'h0;
            periodic_fetch_addr_q <= {periodic_list_base_q[31:12],
                                      list_index(frame_list_size_q, frame_index), 2'b00};
        end
    end

    // Kill and port ownership; a bus reset is never driven from here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xact_kill_q     <= 1'b0;
            usb_bus_reset_q <= 1'b0;
            companion_own_q <= 1'b1;
        end else begin
            xact_kill_q     <= soft_reset_q;
            usb_bus_reset_q <= 1'b0;
            companion_own_q <= soft_reset_q || !port_route_q;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_run_write;
        wr_acc && paddr == `HC_OFS_COMMAND && pwdata[`HC_CMD_RS] && !soft_reset_q
            && halted_flag_q;
    endsequence

    sequence s_running;
        st_q == host_cmd_pkg::ST_RUNNING;
    endsequence

    property p_run_starts;
        @(posedge pclk) disable iff (!presetn)
        s_run_write |=> run_stop_bit_q ##1 s_running ##1 sched_run_q && !halted_flag_q;
    endproperty
    a_run_starts: assert property (p_run_starts) else $error("run write did not start");

    property p_keep_running;
        @(posedge pclk) disable iff (!presetn)
        st_q == host_cmd_pkg::ST_RUNNING && run_stop_bit_q && !soft_reset_q |=> s_running;
    endproperty
    a_keep_running: assert property (p_keep_running) else $error("run dropped");

    property p_stop_bound;
        @(posedge pclk) disable iff (!presetn)
        st_q == host_cmd_pkg::ST_STOPPING && !soft_reset_q && uf_tick &&
            stop_uf_q == 5'(`HC_STOP_UFRAMES - 1) |=> st_q == host_cmd_pkg::ST_HALTED;
    endproperty
    a_stop_bound: assert property (p_stop_bound) else $error("stop overran limit");

    property p_halt_flag;
        @(posedge pclk) disable iff (!presetn)
        st_q == host_cmd_pkg::ST_STOPPING && !usb_xact_busy && !soft_reset_q
            |=> ##1 halted_flag_q;
    endproperty
    a_halt_flag: assert property (p_halt_flag) else $error("halted flag missing");

    property p_srst_restore;
        @(posedge pclk) disable iff (!presetn)
        srst_done |=> !soft_reset_q && !run_stop_bit_q && !async_sched_enable_q
            && frame_list_size_q == `HC_FLS_RESET && st_q == host_cmd_pkg::ST_HALTED;
    endproperty
    a_srst_restore: assert property (p_srst_restore) else $error("soft reset left state");

    property p_srst_length;
        @(posedge pclk) disable iff (!presetn)
        $rose(soft_reset_q) |-> soft_reset_q [*8] ##1 !soft_reset_q;
    endproperty
    a_srst_length: assert property (p_srst_length) else $error("reset length wrong");

    property p_srst_kill;
        @(posedge pclk) disable iff (!presetn)
        soft_reset_q |=> xact_kill_q && companion_own_q && !usb_bus_reset_q;
    endproperty
    a_srst_kill: assert property (p_srst_kill) else $error("reset did not kill");

    property p_fls_guard;
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == `HC_OFS_COMMAND && !soft_reset_q &&
            (!PROG_FLS || pwdata[`HC_CMD_FLS_HI:`HC_CMD_FLS_LO] == `HC_FLS_RSVD)
            |=> $stable(frame_list_size_q);
    endproperty
    a_fls_guard: assert property (p_fls_guard) else $error("size field changed");

    property p_index_sel;
        @(posedge pclk) disable iff (!presetn)
        frame_list_size_q == `HC_FLS_256 && $stable(frame_list_size_q)
            |=> frame_list_index_q == {2'b00, $past(frame_index[10:3])};
    endproperty
    a_index_sel: assert property (p_index_sel) else $error("wrong index bits");

    property p_sched_gates;
        @(posedge pclk) disable iff (!presetn)
        (periodic_fetch_q |-> $past(periodic_active_q)) and
        (async_active_q |-> $past(async_sched_enable_q));
    endproperty
    a_sched_gates: assert property (p_sched_gates) else $error("schedule not gated");

endmodule

// *** usb_xact_model.sv ***
// Behavioural USB transaction engine beside the host command block.
// Assumes the bench raises stall to keep one transaction in flight.
`timescale 1ns/1ps

module usb_xact_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sched_run_q,
    input  wire logic xact_kill_q,
    input  wire logic stall,
    output logic      usb_xact_busy
);
    // A transaction stays in flight while stalled; a kill drops it at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_xact_busy <= 1'b0;
        end else begin
            usb_xact_busy <= sched_run_q & stall & ~xact_kill_q;
        end
    end
endmodule

// *** tb_top.sv ***
// Self-checking bench of the host command block over APB.
// Assumes one 25 MHz clock and the behavioural transaction engine.
`timescale 1ns/1ps

module tb_top;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, busy, e;
    logic        run, pact, aact, fetch, kill, busrst, comp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, faddr, r;
    logic [9:0]  fidx;
    int          bad_count, compares, n;

    usb_host_command_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .usb_xact_busy(busy),
        .sched_run_q(run), .periodic_active_q(pact), .async_active_q(aact),
        .periodic_fetch_q(fetch), .periodic_fetch_addr_q(faddr),
        .frame_list_index_q(fidx), .xact_kill_q(kill), .usb_bus_reset_q(busrst),
        .companion_own_q(comp));
    usb_xact_model far (.pclk(pclk), .presetn(presetn), .sched_run_q(run),
        .xact_kill_q(kill), .stall(stall), .usb_xact_busy(busy));

    // ************************************************************
    // Helpers
    // ************************************************************
    // One APB transfer; ready, read data and error are taken at the rising edge
    // that completes the access, and only the watchdog ends a long wait.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", s, x, g);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        apb(0, 12'h000, 32'h0); chk("cmd", 32'h0, r);
        apb(0, 12'h004, 32'h0); chk("halted", 1, r[12]);
        apb(0, 12'h008, 32'h0); chk("prog", 1, r[1]);
        chk("comp", 1, comp);
    endtask

    task automatic t_cfg;
        apb(1, 12'h000, 32'h34); apb(0, 12'h000, 32'h0); chk("cmd", 32'h34, r);
        apb(1, 12'h000, 32'h3C); apb(0, 12'h000, 32'h0); chk("fls", 32'h34, r);
        apb(1, 12'h00C, 32'h3FF8);
        repeat (2) @(negedge pclk);
        chk("fidx512", 32'h1FF, fidx);
        apb(1, 12'h000, 32'h38);
        repeat (2) @(negedge pclk);
        chk("fidx256", 32'h0FF, fidx);
        apb(1, 12'h000, 32'h30);
        repeat (2) @(negedge pclk);
        chk("fidx1024", 32'h3FF, fidx);
        apb(0, 12'h018, 32'h0); chk("err", 1, e);
        apb(1, 12'h010, 32'hABCDE000);
    endtask

    // Run with both schedules on, then wait for a periodic fetch.
    task automatic t_run;
        apb(1, 12'h000, 32'h35);
        repeat (4) @(negedge pclk);
        chk("run", 1, run); chk("pact", 1, pact); chk("aact", 1, aact);
        apb(0, 12'h004, 32'h0); chk("halted", 0, r[12]);
        n = 0;
        while (fetch !== 1'b1 && n < 26000) begin
            @(negedge pclk);
            n++;
        end
        chk("fetch", 1, fetch); chk("fbase", 32'hABCDE, faddr[31:12]);
        chk("still", 1, run);
    endtask

    // A stalled transaction forces the halt onto the 16 micro-frame limit.
    task automatic t_stop;
        @(posedge pclk);
        stall <= 1'b1;
        apb(1, 12'h000, 32'h34);
        n = 0;
        while (run !== 1'b0 && n < 60000) begin
            @(negedge pclk);
            n++;
        end
        chk("stop_hi", 1, n <= 16 * 3125 + 8); chk("stop_lo", 1, n >= 15 * 3125);
        @(posedge pclk);
        stall <= 1'b0;
        apb(0, 12'h004, 32'h0); chk("halted", 1, r[12]);
        // With nothing in flight a stop completes within a few cycles.
        apb(1, 12'h000, 32'h35);
        repeat (4) @(negedge pclk);
        chk("rerun", 1, run);
        apb(1, 12'h000, 32'h34);
        repeat (4) @(negedge pclk);
        chk("quick", 0, run);
    endtask

    // Soft reset from halted; a write of zero must not cut it short.
    task automatic t_srst;
        apb(1, 12'h014, 32'h1);
        repeat (2) @(negedge pclk);
        chk("own", 0, comp);
        apb(1, 12'h000, 32'h2);
        repeat (2) @(negedge pclk);
        chk("kill", 1, kill); chk("busrst", 0, busrst);
        apb(1, 12'h000, 32'h0);
        apb(0, 12'h000, 32'h0); chk("srst", 1, r[1]);
        repeat (12) @(negedge pclk);
        apb(0, 12'h000, 32'h0); chk("cmd", 32'h0, r);
        chk("comp", 1, comp); apb(0, 12'h014, 32'h0); chk("route", 0, r);
    endtask

    // ************************************************************
    // Clock, reset, sequence and watchdog
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; stall = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; bad_count = 0; compares = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset; t_cfg; t_run; t_stop; t_srst;
        finish_test;
    end

    // The sequence needs about 80000 cycles; a hang ends the run here.
    initial begin
        repeat (100000) @(posedge pclk);
        bad_count++;
        finish_test;
    end
endmodule
